/* core/brake_interlock_pkg.sv */
// constants, register map and states of the holding-brake interlock
package brake_interlock_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned MS_TIME_NS     = 1000000;
  localparam int unsigned MS_CYCLE_COUNT = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TIME_STEP_MS   = 10;      // unit of basic wait and brake wait time

  // register byte offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] OUTSEL_OFS      = 8'h04;
  localparam logic [7:0] ON_WAIT_OFS     = 8'h08;
  localparam logic [7:0] BASIC_WAIT_OFS  = 8'h0c;
  localparam logic [7:0] WAIT_SPEED_OFS  = 8'h10;
  localparam logic [7:0] WAIT_TIME_OFS   = 8'h14;
  localparam logic [7:0] STATUS_OFS      = 8'h18;

  // setting ranges and values after reset
  localparam int          ON_WAIT_MIN     = -2000;
  localparam int          ON_WAIT_MAX     = 2000;
  localparam int          BASIC_WAIT_MAX  = 500;
  localparam int          WAIT_SPEED_MIN  = 10;
  localparam int          WAIT_SPEED_MAX  = 100;
  localparam int          WAIT_TIME_MIN   = 10;
  localparam int          WAIT_TIME_MAX   = 100;
  localparam logic [11:0] OUTSEL_RST      = 12'h000;
  localparam logic [11:0] ON_WAIT_RST     = 12'h000;
  localparam logic [8:0]  BASIC_WAIT_RST  = 9'h000;
  localparam logic [6:0]  WAIT_SPEED_RST  = 7'h64;  // 100 rpm
  localparam logic [6:0]  WAIT_TIME_RST   = 7'h32;  // 50 steps of 10 ms

  // output function codes of one selection digit
  localparam logic [3:0] FN_MATCH    = 4'h0;
  localparam logic [3:0] FN_ROTATING = 4'h1;
  localparam logic [3:0] FN_READY    = 4'h2;
  localparam logic [3:0] FN_TQ_LIMIT = 4'h3;
  localparam logic [3:0] FN_BRAKE    = 4'h4;
  localparam logic [3:0] FN_INDEX    = 4'h5;
  localparam logic [3:0] FN_TRAVEL   = 4'h6;
  localparam logic [3:0] FN_EXCITED  = 4'h7;
  localparam logic [3:0] FN_HOMED    = 4'h8;
  localparam logic [3:0] FN_TQ_DET   = 4'h9;

  // brake sequencer states
  typedef enum logic [5:0] {
    ST_OFF   = 6'b000001,  // servo off, brake applied
    ST_START = 6'b000010,  // servo on, brake held until on-delay ends
    ST_RUN   = 6'b000100,  // servo on, brake released
    ST_HOLD  = 6'b001000,  // brake applied, servo kept on for the delay
    ST_LAG   = 6'b010000,  // servo off, brake applied after the delay
    ST_COAST = 6'b100000   // servo off while turning, wait speed or time
  } brake_state_t;

endpackage : brake_interlock_pkg

/* core/holding_brake_interlock.sv */
// holding-brake interlock sequencer with an AHB-Lite register slave
// Behaviour
// (R1) The brake release output is low to release the brake and high to apply it.
// (R2) Out of reset no terminal carries the brake release output until a selection digit names it.
// (R3) The selection holds three hex digits, one per terminal pair, and digit 4 routes the brake.
// (R4) Digit codes 0 to 9 pick match, rotating, ready, torque limit, brake, index, travel, excited, homed, torque detect.
// (R5) With default settings the brake applies in the same cycle as servo off; a signed ms wait shifts servo timing.
// (R6) A basic wait of 0 to 500 steps of 10 ms adds to the servo on/off delay against the brake.
// (R7) Any alarm turns the servo off at once and ignores the wait delays.
// (R8) After servo off or alarm while running, the brake applies once speed falls below the wait speed.
// (R9) After servo off while running, the brake also applies once the brake wait time elapses.
// (R10) From reset and before servo on the brake release output stays at the applied level.
// (R11) Changed timing settings take effect at the next stop sequence without a restart.
`timescale 1ns/1ps
module holding_brake_interlock
  import brake_interlock_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLE_COUNT
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // drive status
  input  wire logic        ALARM,
  input  wire logic [15:0] MOTOR_SPEED,
  input  wire logic [9:0]  FUNC_IN_N,
  // drive outputs
  output logic             SERVO_ON,
  output logic [2:0]       TERM_OUT_N
);

  // clamp a written setting into its legal range
  function automatic int clamp_int(input int v, input int lo, input int hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : clamp_int

  // settings and bus state
  logic               servo_req_r,  servo_req_nxt;
  logic [11:0]        outsel_r,     outsel_nxt;
  logic signed [11:0] on_wait_r,    on_wait_nxt;
  logic [8:0]         basic_r,      basic_nxt;
  logic [6:0]         wspeed_r,     wspeed_nxt;
  logic [6:0]         wtime_r,      wtime_nxt;
  logic               wr_pend_r,    wr_pend_nxt;
  logic [7:0]         wr_addr_r,    wr_addr_nxt;
  logic [31:0]        rdata_r,      rdata_nxt;
  // sequencer state
  brake_state_t       state_r,      state_nxt;
  logic [16:0]        presc_r,      presc_nxt;
  logic [13:0]        ms_cnt_r,     ms_cnt_nxt;
  logic [13:0]        limit_r,      limit_nxt;
  logic               use_time_r,   use_time_nxt;
  logic               servo_en_r,   servo_en_nxt;
  logic               brake_rel_n_r, brake_rel_n_nxt;
  logic [2:0]         term_r,       term_nxt;
  // alarm pin synchroniser
  logic               alarm_meta_r, alarm_r;

  logic               addr_ok;
  logic               running;
  logic               ms_tick;
  logic               elapsed;
  int                 delay_ms;

  assign addr_ok  = HSEL && HTRANS[1] && HREADY;
  assign running  = MOTOR_SPEED >= {9'h000, wspeed_r};
  assign ms_tick  = presc_r == 17'(MS_CYCLES - 1);
  assign elapsed  = ms_cnt_r >= limit_r;
  // on/off delay sampled when a sequence starts, so edits apply to the next one
  assign delay_ms = int'(on_wait_r) + int'(basic_r) * int'(TIME_STEP_MS);  // [R5] [R6] [R11]

  // register file and bus answer
  always_comb begin
    servo_req_nxt = servo_req_r;
    outsel_nxt    = outsel_r;
    on_wait_nxt   = on_wait_r;
    basic_nxt     = basic_r;
    wspeed_nxt    = wspeed_r;
    wtime_nxt     = wtime_r;
    wr_pend_nxt   = addr_ok && HWRITE;
    wr_addr_nxt   = addr_ok ? HADDR[7:0] : wr_addr_r;
    rdata_nxt     = rdata_r;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        CTRL_OFS:       servo_req_nxt = HWDATA[0];
        OUTSEL_OFS:     outsel_nxt    = HWDATA[11:0];  // [R3]
        ON_WAIT_OFS:    on_wait_nxt   = 12'(clamp_int(int'($signed(HWDATA[15:0])),
                                                      ON_WAIT_MIN, ON_WAIT_MAX));  // [R5]
        BASIC_WAIT_OFS: basic_nxt     = 9'(clamp_int(int'(HWDATA[15:0]), 0,
                                                     BASIC_WAIT_MAX));  // [R6]
        WAIT_SPEED_OFS: wspeed_nxt    = 7'(clamp_int(int'(HWDATA[15:0]), WAIT_SPEED_MIN,
                                                     WAIT_SPEED_MAX));  // [R8]
        WAIT_TIME_OFS:  wtime_nxt     = 7'(clamp_int(int'(HWDATA[15:0]), WAIT_TIME_MIN,
                                                     WAIT_TIME_MAX));  // [R9]
        default:        ;
      endcase
    end
    // read data is captured in the address phase, so a read right behind a
    // write to the same register sees the old value
    if (addr_ok && !HWRITE) begin
      unique case (HADDR[7:0])
        CTRL_OFS:       rdata_nxt = {31'h0, servo_req_r};
        OUTSEL_OFS:     rdata_nxt = {20'h0, outsel_r};
        ON_WAIT_OFS:    rdata_nxt = 32'($signed(on_wait_r));
        BASIC_WAIT_OFS: rdata_nxt = {23'h0, basic_r};
        WAIT_SPEED_OFS: rdata_nxt = {25'h0, wspeed_r};
        WAIT_TIME_OFS:  rdata_nxt = {25'h0, wtime_r};
        STATUS_OFS:     rdata_nxt = {18'h0, state_r, 5'h0, alarm_r, ~brake_rel_n_r, servo_en_r};
        default:        rdata_nxt = 32'h0;
      endcase
    end else if (addr_ok) begin
      rdata_nxt = 32'h0;
    end
  end

  // register file flip-flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      servo_req_r <= 1'b0;
      outsel_r    <= OUTSEL_RST;  // [R2]
      on_wait_r   <= ON_WAIT_RST;
      basic_r     <= BASIC_WAIT_RST;
      wspeed_r    <= WAIT_SPEED_RST;
      wtime_r     <= WAIT_TIME_RST;
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 8'h00;
      rdata_r     <= 32'h0;
      HREADYOUT   <= 1'b1;
      HRESP       <= 1'b0;
    end else begin
      servo_req_r <= servo_req_nxt;
      outsel_r    <= outsel_nxt;
      on_wait_r   <= on_wait_nxt;
      basic_r     <= basic_nxt;
      wspeed_r    <= wspeed_nxt;
      wtime_r     <= wtime_nxt;
      wr_pend_r   <= wr_pend_nxt;
      wr_addr_r   <= wr_addr_nxt;
      rdata_r     <= rdata_nxt;
      HREADYOUT   <= 1'b1;  // zero wait states, always okay
      HRESP       <= 1'b0;
    end
  end

  assign HRDATA = rdata_r;

  // alarm pin synchroniser; only the second stage is used
  always_ff @(posedge CLK) begin
    if (SRST) begin
      alarm_meta_r <= 1'b0;
      alarm_r      <= 1'b0;
    end else begin
      alarm_meta_r <= ALARM;
      alarm_r      <= alarm_meta_r;
    end
  end

  // brake sequencer: next state, timers and drive levels
  always_comb begin
    state_nxt       = state_r;
    limit_nxt       = limit_r;
    use_time_nxt    = use_time_r;
    servo_en_nxt    = servo_en_r;
    brake_rel_n_nxt = brake_rel_n_r;
    unique case (state_r)
      ST_OFF: begin
        servo_en_nxt    = 1'b0;
        brake_rel_n_nxt = 1'b1;  // [R1] [R10]
        if (servo_req_r && !alarm_r) begin
          servo_en_nxt = 1'b1;
          if (delay_ms > 0) begin
            limit_nxt = 14'(delay_ms);
            state_nxt = ST_START;
          end else begin
            brake_rel_n_nxt = 1'b0;  // [R1]
            state_nxt       = ST_RUN;
          end
        end
      end
      ST_START: begin
        if (alarm_r || !servo_req_r) begin
          servo_en_nxt = 1'b0;  // [R7]
          state_nxt    = ST_OFF;
        end else if (elapsed) begin
          brake_rel_n_nxt = 1'b0;
          state_nxt       = ST_RUN;
        end
      end
      ST_RUN: begin
        if (alarm_r || !servo_req_r) begin
          servo_en_nxt = 1'b0;  // [R7]
          if (running) begin
            // turning: hold the brake off until slow, or until the time runs out
            use_time_nxt = !alarm_r;  // [R9]
            limit_nxt    = 14'(int'(wtime_r) * int'(TIME_STEP_MS));  // [R9] [R11]
            state_nxt    = ST_COAST;
          end else if (alarm_r || delay_ms == 0) begin
            brake_rel_n_nxt = 1'b1;  // [R5] [R7]
            state_nxt       = ST_OFF;
          end else if (delay_ms > 0) begin
            // brake first, servo held on so a vertical load cannot sag
            servo_en_nxt    = 1'b1;  // [R6]
            brake_rel_n_nxt = 1'b1;
            limit_nxt       = 14'(delay_ms);
            state_nxt       = ST_HOLD;
          end else begin
            limit_nxt = 14'(-delay_ms);  // [R5]
            state_nxt = ST_LAG;
          end
        end
      end
      ST_HOLD: begin
        if (alarm_r || elapsed) begin
          servo_en_nxt = 1'b0;  // [R7]
          state_nxt    = ST_OFF;
        end
      end
      ST_LAG: begin
        if (alarm_r || elapsed) begin
          brake_rel_n_nxt = 1'b1;  // [R7]
          state_nxt       = ST_OFF;
        end
      end
      ST_COAST: begin
        if (!running || (use_time_r && elapsed)) begin
          brake_rel_n_nxt = 1'b1;  // [R8] [R9]
          state_nxt       = ST_OFF;
        end
      end
      default: begin
        servo_en_nxt    = 1'b0;
        brake_rel_n_nxt = 1'b1;
        state_nxt       = ST_OFF;
      end
    endcase
    // millisecond count restarts with every state change
    presc_nxt  = (state_nxt != state_r || ms_tick) ? 17'h0 : presc_r + 17'h1;
    ms_cnt_nxt = (state_nxt != state_r) ? 14'h0 :
                 (ms_tick && !elapsed) ? ms_cnt_r + 14'h1 : ms_cnt_r;
  end

  // terminal routing: each digit picks one function for its pair
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (outsel_r[4*i +: 4] == FN_BRAKE) begin
        term_nxt[i] = brake_rel_n_nxt;  // [R2] [R3]
      end else if (outsel_r[4*i +: 4] <= FN_TQ_DET) begin
        term_nxt[i] = FUNC_IN_N[outsel_r[4*i +: 4]];  // [R4]
      end else begin
        term_nxt[i] = 1'b1;  // undefined code leaves the pair off
      end
    end
  end

  // sequencer flip-flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r       <= ST_OFF;
      presc_r       <= 17'h0;
      ms_cnt_r      <= 14'h0;
      limit_r       <= 14'h0;
      use_time_r    <= 1'b0;
      servo_en_r    <= 1'b0;
      brake_rel_n_r <= 1'b1;  // [R10]
      term_r        <= 3'b111;
    end else begin
      state_r       <= state_nxt;
      presc_r       <= presc_nxt;
      ms_cnt_r      <= ms_cnt_nxt;
      limit_r       <= limit_nxt;
      use_time_r    <= use_time_nxt;
      servo_en_r    <= servo_en_nxt;
      brake_rel_n_r <= brake_rel_n_nxt;
      term_r        <= term_nxt;
    end
  end

  assign SERVO_ON   = servo_en_r;
  assign TERM_OUT_N = term_r;

endmodule : holding_brake_interlock

/* verification/brake_interlock_asserts.sv */
// port assertions for the holding-brake interlock
`timescale 1ns/1ps
module brake_interlock_asserts
  import brake_interlock_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 10
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // drive
  input wire logic        ALARM,
  input wire logic [15:0] MOTOR_SPEED,
  input wire logic [9:0]  FUNC_IN_N,
  input wire logic        SERVO_ON,
  input wire logic [2:0]  TERM_OUT_N
);
  // longest legal released-brake stop is the 2000 ms servo lead
  localparam int unsigned LAG_MAX = 2000 * MS_CYCLES + 8;
  logic        wr_pend_r;
  logic        alarm_seen_r;
  logic [7:0]  wr_addr_r;
  logic [3:0]  sel_r;
  int unsigned off_cnt_r;
  // snoop selection digit 0; count servo-off cycles with brake still released
  always_ff @(posedge CLK) begin
    if (SRST) begin
      wr_pend_r    <= 1'b0;
      wr_addr_r    <= 8'h00;
      alarm_seen_r <= 1'b0;
      sel_r        <= 4'h0;
      off_cnt_r    <= 0;
    end else begin
      wr_pend_r    <= HSEL && HTRANS[1] && HREADY && HWRITE;
      wr_addr_r    <= HADDR[7:0];
      if (wr_pend_r && wr_addr_r == OUTSEL_OFS) sel_r <= HWDATA[3:0];
      alarm_seen_r <= !SERVO_ON && (alarm_seen_r || ALARM);
      // alarm stops wait on speed alone, so they are left out of the count
      off_cnt_r    <= (SERVO_ON || TERM_OUT_N[0] || alarm_seen_r || sel_r != FN_BRAKE) ?
                      0 : off_cnt_r + 1;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  property p_reset_safe;
    disable iff (1'b0) SRST |=> !SERVO_ON && TERM_OUT_N == 3'b111;
  endproperty
  a_reset_safe: assert property (p_reset_safe) else $error("outputs unsafe in reset");
  property p_bus_okay;
    HREADYOUT && !HRESP;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
  property p_alarm_off;
    ALARM [*3] |=> !SERVO_ON;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("servo on during alarm");
  property p_release_on;
    $fell(TERM_OUT_N[0]) && $stable(sel_r) && sel_r == FN_BRAKE |-> SERVO_ON;
  endproperty
  a_release_on: assert property (p_release_on) else $error("brake freed unpowered");
  property p_route;
    !$past(SRST) && $stable(sel_r) && $stable(FUNC_IN_N) && sel_r <= 4'h9 && sel_r != FN_BRAKE
      |-> TERM_OUT_N[0] == FUNC_IN_N[sel_r];
  endproperty
  a_route: assert property (p_route) else $error("terminal routing wrong");
  property p_unused_code;
    $stable(sel_r) && sel_r > 4'h9 |-> TERM_OUT_N[0];
  endproperty
  a_unused_code: assert property (p_unused_code) else $error("unused code drives pin");
  property p_stop_bound;
    off_cnt_r <= LAG_MAX;
  endproperty
  a_stop_bound: assert property (p_stop_bound) else $error("brake apply too late");
  property p_alarm_slow;
    (alarm_seen_r && !SERVO_ON && sel_r == FN_BRAKE && MOTOR_SPEED < 16'd10) [*3]
      |=> TERM_OUT_N[0];
  endproperty
  a_alarm_slow: assert property (p_alarm_slow) else $error("brake free at standstill");
  c_release: cover property ($fell(TERM_OUT_N[0]) && sel_r == FN_BRAKE);
  c_lag: cover property (off_cnt_r == 40);
  c_alarm: cover property (ALARM && SERVO_ON);
endmodule : brake_interlock_asserts

/* verification/brake_relay_model.sv */
// brake relay and motor load behind the brake release terminal
`timescale 1ns/1ps
module brake_relay_model (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // drive side
  input  wire logic        brake_n,
  input  wire logic        servo_on,
  // load profile
  input  wire logic [15:0] target,
  input  wire logic [15:0] decel,
  output logic      [15:0] speed
);
  logic relay_on;
  // coil pulls in only while the line is driven low; unknown counts as applied
  assign relay_on = (brake_n === 1'b0);
  // energised motor follows target, coasts when freed, is held once the brake grips
  always_ff @(posedge CLK) begin
    if (SRST) speed <= 16'h0000;
    else if (servo_on) speed <= target;
    else if (!relay_on) speed <= 16'h0000;
    else speed <= (speed > decel) ? speed - decel : 16'h0000;
  end
endmodule : brake_relay_model

/* verification/holding_brake_interlock_bench.sv */
// self-checking bench for the holding-brake interlock
`timescale 1ns/1ps
module holding_brake_interlock_bench;
  import brake_interlock_pkg::*;
  localparam int unsigned MSC = 10;
  localparam int unsigned STEP = TIME_STEP_MS * MSC;
  logic        CLK, SRST, HSEL, HWRITE, ALARM;
  logic [31:0] HADDR, HWDATA, rd;
  logic [1:0]  HTRANS;
  logic [9:0]  FUNC_IN_N;
  logic [15:0] target, decel;
  wire  [31:0] HRDATA;
  wire         HREADYOUT, HRESP, SERVO_ON;
  wire  [15:0] MOTOR_SPEED;
  wire  [2:0]  TERM_OUT_N;
  int          failures, checks_done, tb, ts, t;
  logic [7:0]  ra [8] = '{CTRL_OFS, OUTSEL_OFS, ON_WAIT_OFS, BASIC_WAIT_OFS, WAIT_SPEED_OFS,
                          WAIT_TIME_OFS, STATUS_OFS, 8'h1c};
  logic [31:0] rv [8] = '{0, 32'(OUTSEL_RST), 32'(ON_WAIT_RST), 32'(BASIC_WAIT_RST),
                          32'(WAIT_SPEED_RST), 32'(WAIT_TIME_RST), {18'h0, ST_OFF, 8'h00}, 0};
  // clamp corners: offset, word written, value read back, value restored afterwards
  logic [7:0]  ca [5] = '{ON_WAIT_OFS, ON_WAIT_OFS, BASIC_WAIT_OFS, WAIT_SPEED_OFS,
                          WAIT_TIME_OFS};
  logic [31:0] cw [5] = '{32'h1000, 32'hf000, 32'hffff, 32'h5, 32'hff};
  logic [31:0] cx [5] = '{32'(ON_WAIT_MAX), 32'(ON_WAIT_MIN), 32'(BASIC_WAIT_MAX),
                          32'(WAIT_SPEED_MIN), 32'(WAIT_TIME_MAX)};
  logic [31:0] cd [5] = '{0, 0, 0, 32'(WAIT_SPEED_RST), 32'(WAIT_TIME_RST)};
  holding_brake_interlock #(.MS_CYCLES(MSC)) uut (
    .CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ALARM(ALARM), .MOTOR_SPEED(MOTOR_SPEED),
    .FUNC_IN_N(FUNC_IN_N), .SERVO_ON(SERVO_ON), .TERM_OUT_N(TERM_OUT_N));
  brake_relay_model load (.CLK(CLK), .SRST(SRST), .brake_n(TERM_OUT_N[0]), .servo_on(SERVO_ON),
    .target(target), .decel(decel), .speed(MOTOR_SPEED));
  // free-running clock
  initial begin
    CLK = 1'b0;
    forever #(CLK_PERIOD_NS / 2) CLK = ~CLK;
  end
  // hang guard, far beyond the few thousand cycles the sequence needs
  initial begin
    #(20000 * CLK_PERIOD_NS);
    failures++;
    final_report();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one word transfer; the master waits for ready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR  <= {24'h0, a};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask : ahb
  // cycles from the last request edge until brake and servo reach the given levels
  task automatic meas(input logic bl, input logic sl);
    int n;
    n  = 0;
    tb = -1;
    ts = -1;
    while ((tb < 0 || ts < 0) && n < 5000) begin
      @(posedge CLK);
      #1;
      n++;
      if (tb < 0 && TERM_OUT_N[0] === bl) tb = n;
      if (ts < 0 && SERVO_ON === sl) ts = n;
    end
    chk(n < 5000, 1'b1);
  endtask : meas
  function automatic bit near(input int got, input int exp);
    return got >= exp - 1 && got <= exp + 3;
  endfunction : near
  // brake is applied while the servo is off, so its digit reads high
  function automatic logic exp_term(input logic [3:0] c, input logic [9:0] f);
    if (c == FN_BRAKE || c > 4'h9) return 1'b1;
    return f[c];
  endfunction : exp_term
  task automatic seq(input int rel, input int app, input int drp);
    ahb(1'b1, CTRL_OFS, 32'h1);
    meas(1'b0, 1'b1);
    chk(near(tb, rel) && near(ts, 1), 1'b1);
    ahb(1'b1, CTRL_OFS, 32'h0);
    meas(1'b1, 1'b0);
    chk(near(tb, app) && near(ts, drp), 1'b1);
  endtask : seq
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    void'($urandom(40680));
    {SRST, HSEL, HWRITE, ALARM, HADDR, HWDATA, HTRANS, target, decel} = '0;
    SRST      = 1'b1;
    FUNC_IN_N = '1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    #1;
    chk({SERVO_ON, TERM_OUT_N}, 4'b0111);
    foreach (ra[i]) begin
      ahb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    // out-of-range settings land on the nearest legal value; defaults are put back
    foreach (ca[i]) begin
      ahb(1'b1, ca[i], cw[i]);
      ahb(1'b0, ca[i], 32'h0);
      chk(rd, cx[i]);
      ahb(1'b1, ca[i], cd[i]);
    end
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c <= 10; c++) begin
        ahb(1'b1, OUTSEL_OFS, 32'(c) << (4 * p));
        FUNC_IN_N <= 10'($urandom);
        repeat (3) @(posedge CLK);
        #1;
        chk(TERM_OUT_N[p], exp_term(4'(c), FUNC_IN_N));
      end
    end
    $display("test routing done");
    ahb(1'b1, OUTSEL_OFS, 32'h004);
    seq(1, 1, 1);
    chk(tb == ts, 1'b1);
    ahb(1'b1, BASIC_WAIT_OFS, 32'h1);
    seq(1 + STEP, 1, 1 + STEP);
    ahb(1'b1, BASIC_WAIT_OFS, 32'h0);
    ahb(1'b1, ON_WAIT_OFS, 32'hfffb);
    seq(1, 1 + 5 * MSC, 1);
    $display("test delays done");
    ahb(1'b1, ON_WAIT_OFS, 32'h0);
    t = 200 + $urandom % 500;
    target <= 16'(t);
    decel  <= 16'h0001;
    seq(1, t - 97, 1);
    ahb(1'b1, WAIT_TIME_OFS, 32'(WAIT_TIME_MIN));
    target <= 16'd500;
    decel  <= 16'h0000;
    seq(1, 1 + WAIT_TIME_MIN * STEP, 1);
    $display("test running stop done");
    target <= 16'h0000;
    ahb(1'b1, BASIC_WAIT_OFS, 32'h2);
    ahb(1'b1, CTRL_OFS, 32'h1);
    meas(1'b0, 1'b1);
    chk(near(tb, 1 + 2 * STEP), 1'b1);
    @(posedge CLK);
    ALARM <= 1'b1;
    meas(1'b1, 1'b0);
    chk(near(tb, 3) && near(ts, 3), 1'b1);
    ahb(1'b1, CTRL_OFS, 32'h0);
    ahb(1'b1, CTRL_OFS, 32'h1);
    repeat (20) @(posedge CLK);
    #1;
    chk(SERVO_ON, 1'b0);
    // alarm seen, servo off, brake applied, sequencer idle
    ahb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, {18'h0, ST_OFF, 8'h04});
    ahb(1'b1, CTRL_OFS, 32'h0);
    ALARM <= 1'b0;
    $display("test alarm done");
    final_report();
  end
endmodule : holding_brake_interlock_bench

bind holding_brake_interlock brake_interlock_asserts #(.MS_CYCLES(MS_CYCLES)) asrt (
  .CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ALARM(ALARM),
  .MOTOR_SPEED(MOTOR_SPEED), .FUNC_IN_N(FUNC_IN_N), .SERVO_ON(SERVO_ON), .TERM_OUT_N(TERM_OUT_N));
